// file: pfbi_defs.svh
// timing counts and field constants for the parallel flash bus host controller
`ifndef PFBI_DEFS_SVH
`define PFBI_DEFS_SVH

// =====================================================================
// clock
`define PFBI_CLK_NS          10
// =====================================================================
// timing in ns and derived cycle counts (least times round up)
`define PFBI_RESET_NS        500
`define PFBI_RESET_CYC       ((`PFBI_RESET_NS + `PFBI_CLK_NS - 1) / `PFBI_CLK_NS)
`define PFBI_RECOVER_NS      50
`define PFBI_RECOVER_CYC     ((`PFBI_RECOVER_NS + `PFBI_CLK_NS - 1) / `PFBI_CLK_NS)
`define PFBI_RAMP_NS         500
`define PFBI_RAMP_CYC        ((`PFBI_RAMP_NS + `PFBI_CLK_NS - 1) / `PFBI_CLK_NS + 1)
`define PFBI_PROT_NS         100000
`define PFBI_PROT_CYC        ((`PFBI_PROT_NS + `PFBI_CLK_NS - 1) / `PFBI_CLK_NS)
`define PFBI_STROBE_CYC      8
// =====================================================================
// protection verify value and idle bus data
`define PFBI_PROT_YES        8'h01
`define PFBI_IDLE_DATA       16'h0000

`endif

// file: pfbi_flash_model.sv
// behavioural boot-block flash device answering the host pins
`timescale 1ns/1ps
module pfbi_flash_model #(
  parameter logic [7:0] MFR_CODE    = 8'h5A, // arbitrary value
  parameter logic [7:0] DEV_CODE    = 8'hA5, // arbitrary value
  parameter int         BUSY_NS     = 2000,
  parameter int         RST_BUSY_NS = 10000
) (
  // strobes; select, gate and reset each with its elevated-level flag, write strobe without one
  input  wire logic        cs_n_i,
  input  wire logic        cs_hv_i,
  input  wire logic        og_n_i,
  input  wire logic        og_hv_i,
  input  wire logic        we_n_i,
  input  wire logic        rp_n_i,
  input  wire logic        rp_hv_i,
  // address and data
  input  wire logic        byte_sel_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        a9_hv_i,
  input  wire logic [15:0] dq_i,
  output logic      [15:0] dq_o,
  output logic      [15:0] dq_en_o,
  // open-drain pull-down only
  output logic             rb_low_o
);
  logic [15:0] mem [16];
  logic [15:0] prot;
  logic [15:0] alat;
  logic [15:0] dlat;
  logic        alsb;
  logic        busy = 1'b0;
  logic        was_busy = 1'b0;
  int          tok = 0;
  realtime     ready_t = 0;
  wire         wr_n = cs_n_i | we_n_i | ~og_n_i;

  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    prot = 16'h0000;
  end
  assign rb_low_o = busy;

  task automatic hold_busy(input int ns);
    int k;
    tok++;
    k = tok;
    busy = 1'b1;
    fork
      begin
        #(ns);
        if (k == tok) busy = 1'b0;
      end
    join_none
  endtask : hold_busy

  // =====================================================================
  // write path
  always @(negedge wr_n) begin
    alat = addr_i;
    alsb = dq_i[15];
    dlat = dq_i;
  end
  // host may release data in the same step as the strobe rises
  always @(dq_i) if (!wr_n) dlat = dq_i;
  always @(posedge wr_n) begin
    if (!a9_hv_i && !og_hv_i && !busy && rp_n_i && $realtime >= ready_t) begin
      if (!prot[alat[15:12]] || rp_hv_i) begin
        if (byte_sel_i) mem[alat[3:0]] = dlat;
        else mem[alat[3:0]][8*alsb +: 8] = dlat[7:0];
        hold_busy(BUSY_NS);
      end
    end
  end
  always @(posedge we_n_i) begin
    if (a9_hv_i && og_hv_i) begin
      if (cs_hv_i) prot = 16'h0000;
      else prot[addr_i[15:12]] = 1'b1;
    end
  end

  // =====================================================================
  // reset pin
  always @(negedge rp_n_i) begin
    was_busy = busy;
    if (busy) tok++;
  end
  always @(posedge rp_n_i) begin
    ready_t = $realtime + 50;
    if (was_busy) begin
      mem[alat[3:0]] = ~dlat;
      hold_busy(RST_BUSY_NS);
    end
  end

  // =====================================================================
  // read path
  always @* begin
    dq_o = mem[addr_i[3:0]];
    if (a9_hv_i && !addr_i[1]) dq_o = {8'h00, addr_i[0] ? DEV_CODE : MFR_CODE};
    else if (a9_hv_i && !addr_i[0] && !addr_i[6]) dq_o = {15'h0000, prot[addr_i[15:12]]};
    else if (!byte_sel_i) dq_o = {8'h00, mem[addr_i[3:0]][8*dq_i[15] +: 8]};
    dq_en_o = 16'h0000;
    if (!cs_n_i && !og_n_i && we_n_i && rp_n_i) dq_en_o = byte_sel_i ? 16'hFFFF : 16'h00FF;
  end
endmodule : pfbi_flash_model

// file: pfbi_host.sv
// host-side bus controller driving a parallel boot-block flash through its pins
`timescale 1ns/1ps
`include "pfbi_defs.svh"

// =====================================================================
// Functional notes
// (RULE1) device latches address on the later falling edge of select or write strobe
// (RULE2) device latches data on the earlier rising edge of select or write strobe
// (RULE3) byte mode uses low eight lines, line 15 carries address lsb
// (RULE4) word mode upper byte ignored for commands and status
// (RULE5) device drives data only with select and output gate both low
// (RULE6) host writes with select low, write strobe low, output gate high
// (RULE7) output gate and write strobe high keep device outputs floating
// (RULE8) select high with engine idle puts device in standby, outputs float
// (RULE9) after 150ns idle device enters pseudo-standby, still driving outputs
// (RULE10) busy low while programming or erasing, only suspend accepted
// (RULE11) ready high when idle, suspended or standby; output is open drain
// (RULE12) host holds reset low at least 500ns
// (RULE13) after reset from read or standby, operations accepted 50ns later
// (RULE14) reset during program or erase holds busy low for 10us
// (RULE15) reset during program or erase corrupts affected data
// (RULE16) high voltage on reset pin unprotects; host ramps it slower than 500ns
// (RULE17) address bit9 high voltage reads manufacturer or device code
// (RULE18) signature by command: upper byte 00h in word mode, float in byte mode
// (RULE19) protect: bit9 and gate high voltage, write strobe low 100us
// (RULE20) protect verify reads 01h for a protected block
// (RULE21) device ignores program or erase to protected blocks
// (RULE22) unprotect drives select and gate to high voltage too
// (RULE23) bad command sequence returns device to read array
// (RULE24) high-voltage pins carry a separate elevated-level qualifier
module pfbi_host
  import pfbi_pkg::*;
#(
  parameter int unsigned PROT_CYC = `PFBI_PROT_CYC
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  // user request
  input  wire logic        req_i,
  input  wire pfbi_op_t    op_i,
  input  wire logic        byte_mode_i,
  input  wire logic [16:0] addr_i,
  input  wire logic [15:0] wdata_i,
  output logic             busy_o,
  output logic             done_o,
  output logic [15:0]      rdata_o,
  output logic             dev_ready_o,
  // flash pins
  output logic             chip_select_n_o,
  output logic             chip_select_hv_o,
  output logic             output_gate_n_o,
  output logic             output_gate_hv_o,
  output logic             write_strobe_n_o,
  output logic             reset_unprotect_n_o,
  output logic             reset_unprotect_hv_o,
  output logic             byte_sel_o,
  output logic [15:0]      addr_o,
  output logic             addr_bit9_hv_o,
  input  wire logic [15:0] dq_i,
  output logic [15:0]      dq_o,
  output logic [15:0]      dq_oe_n_o,
  input  wire logic        ready_busy_n_i
);

  pfbi_state_t state;
  pfbi_op_t    op;
  logic [16:0] cnt;
  logic [15:0] dq_s1, dq_s2;
  logic        rb_s1, rb_s2;

  function automatic logic [16:0] cyc17(input int unsigned v);
    cyc17 = v[16:0];
  endfunction : cyc17

  // =====================================================================
  // pin synchronisers: sampled data only read once stable
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
      rb_s1 <= 1'b1;
      rb_s2 <= 1'b1;
    end else begin
      dq_s1 <= dq_i;
      dq_s2 <= dq_s1;
      rb_s1 <= ready_busy_n_i;
      rb_s2 <= rb_s1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) dev_ready_o <= 1'b1;
    else         dev_ready_o <= rb_s2; // [RULE10] [RULE11] [RULE14]
  end

  // =====================================================================
  // sequencer
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= PFBI_IDLE;
      op    <= PFBI_OP_READ;
      cnt   <= 17'h0_0000;
    end else begin
      case (state)
        PFBI_IDLE: begin
          if (req_i) begin
            op    <= op_i;
            cnt   <= cyc17(`PFBI_STROBE_CYC);
            state <= PFBI_SETUP;
          end
        end
        PFBI_SETUP: begin
          // new cycles wait for device ready, except reset and the temporary unprotect off request
          if (rb_s2 || op == PFBI_OP_RESET || op == PFBI_OP_TMP_OFF) begin
            case (op)
              PFBI_OP_RESET:   cnt <= cyc17(`PFBI_RESET_CYC);      // [RULE12]
              PFBI_OP_TMP_ON,
              PFBI_OP_TMP_OFF: cnt <= cyc17(`PFBI_RAMP_CYC);       // [RULE16]
              PFBI_OP_PROTECT,
              PFBI_OP_UNPROT:  cnt <= cyc17(PROT_CYC);             // [RULE19]
              default:         cnt <= cyc17(`PFBI_STROBE_CYC);
            endcase
            state <= PFBI_STROBE;
          end
        end
        PFBI_STROBE: begin
          if (cnt <= 17'h0_0001) begin
            cnt   <= cyc17(`PFBI_RECOVER_CYC);
            state <= (op == PFBI_OP_RESET) ? PFBI_WAIT : PFBI_HOLD;
          end else begin
            cnt <= cnt - 17'h0_0001;
          end
        end
        PFBI_HOLD: begin
          state <= PFBI_DONE;
        end
        PFBI_WAIT: begin
          // recovery after reset release; long reset also waits for ready rise
          if (cnt > 17'h0_0001) cnt <= cnt - 17'h0_0001;  // [RULE13]
          else if (rb_s2)       state <= PFBI_DONE;       // [RULE14]
        end
        PFBI_DONE: begin
          state <= PFBI_IDLE;
        end
        default: state <= PFBI_IDLE;
      endcase
    end
  end

  // =====================================================================
  // pin drive
  logic active;
  assign active = (state == PFBI_STROBE);

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chip_select_n_o     <= 1'b1;
      chip_select_hv_o    <= 1'b0;
      output_gate_n_o     <= 1'b1;
      output_gate_hv_o    <= 1'b0;
      write_strobe_n_o    <= 1'b1;
      reset_unprotect_n_o <= 1'b1;
      byte_sel_o          <= 1'b1;
      addr_o              <= 16'h0000;
      addr_bit9_hv_o      <= 1'b0;
      dq_o                <= `PFBI_IDLE_DATA;
      dq_oe_n_o           <= 16'hFFFF;
    end else begin
      chip_select_n_o  <= 1'b1;                                    // [RULE8]
      chip_select_hv_o <= 1'b0;
      output_gate_n_o  <= 1'b1;                                    // [RULE7]
      output_gate_hv_o <= 1'b0;
      write_strobe_n_o <= 1'b1;
      addr_bit9_hv_o   <= 1'b0;
      dq_oe_n_o        <= 16'hFFFF;
      reset_unprotect_n_o <= 1'b1;
      // hold keeps address, data and hv levels one cycle past the strobe rise
      if (state == PFBI_SETUP || state == PFBI_HOLD || active) begin
        byte_sel_o <= ~byte_mode_i;
        addr_o     <= addr_i[16:1];
        case (op)
          PFBI_OP_WRITE: begin
            chip_select_n_o  <= 1'b0;                              // [RULE6]
            write_strobe_n_o <= ~active;                           // [RULE1] [RULE2]
            dq_o             <= byte_mode_i ? {addr_i[0], 7'h00, wdata_i[7:0]} : wdata_i;
            dq_oe_n_o        <= byte_mode_i ? 16'h7F00 : 16'h0000; // [RULE3] [RULE4]
          end
          PFBI_OP_READ, PFBI_OP_SIG, PFBI_OP_PVERIFY: begin
            chip_select_n_o <= 1'b0;
            output_gate_n_o <= ~active;                            // [RULE5]
            addr_bit9_hv_o  <= (op != PFBI_OP_READ);               // [RULE17] [RULE24]
            if (op == PFBI_OP_PVERIFY) begin
              addr_o[1:0] <= 2'b10;                                // [RULE20]
              addr_o[6]   <= 1'b0;
            end
            if (byte_mode_i) begin
              dq_o      <= {addr_i[0], 15'h0000};
              dq_oe_n_o <= 16'h7FFF;                               // [RULE3]
            end
          end
          PFBI_OP_PROTECT, PFBI_OP_UNPROT: begin
            chip_select_n_o  <= (op == PFBI_OP_UNPROT);
            chip_select_hv_o <= (op == PFBI_OP_UNPROT);            // [RULE22]
            output_gate_hv_o <= 1'b1;                              // [RULE19]
            addr_bit9_hv_o   <= 1'b1;
            write_strobe_n_o <= ~active;
            if (op == PFBI_OP_UNPROT) begin
              addr_o[12] <= 1'b1;
              addr_o[15] <= 1'b1;
            end
          end
          PFBI_OP_RESET: reset_unprotect_n_o <= ~active;           // [RULE12]
          default: ;
        endcase
      end else if (state == PFBI_WAIT) begin
        chip_select_n_o <= 1'b1;
      end
    end
  end

  // temporary unprotect level held until the off request or a reset request; ramp time spent in strobe
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) reset_unprotect_hv_o <= 1'b0;
    else if (state == PFBI_STROBE && cnt == 17'h0_0001 && op == PFBI_OP_TMP_ON) reset_unprotect_hv_o <= 1'b1; // [RULE16]
    else if (state == PFBI_SETUP && op == PFBI_OP_TMP_OFF) reset_unprotect_hv_o <= 1'b0;
    else if (state == PFBI_SETUP && op == PFBI_OP_RESET) reset_unprotect_hv_o <= 1'b0;
  end

  // =====================================================================
  // status and read data
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_o  <= 1'b0;
      done_o  <= 1'b0;
      rdata_o <= 16'h0000;
    end else begin
      busy_o <= (state != PFBI_IDLE && state != PFBI_DONE) || (state == PFBI_IDLE && req_i);
      done_o <= (state == PFBI_HOLD) || (state == PFBI_WAIT && cnt <= 17'h0_0001 && rb_s2);
      if (state == PFBI_HOLD && (op == PFBI_OP_READ || op == PFBI_OP_SIG || op == PFBI_OP_PVERIFY))
        rdata_o <= byte_mode_i ? {8'h00, dq_s2[7:0]} : dq_s2;      // [RULE18]
    end
  end

  // =====================================================================
  // checks
  a_write_gate_high: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !write_strobe_n_o |-> (output_gate_n_o && !(chip_select_n_o && !chip_select_hv_o))) // [RULE6]
    else $error("write strobe low without proper gate or select");
  a_reset_pulse_len: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $fell(reset_unprotect_n_o) |-> !reset_unprotect_n_o [*8]) // [RULE12]
    else $error("reset pulse too short");
  a_protect_hv_pins: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (!write_strobe_n_o && output_gate_hv_o) |-> addr_bit9_hv_o) // [RULE19]
    else $error("protect strobe without bit9 high voltage");
  a_unprot_sel_hv: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (chip_select_hv_o) |-> output_gate_hv_o && addr_o[15] && addr_o[12]) // [RULE22]
    else $error("unprotect without gate high voltage");
  a_no_read_write: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !output_gate_n_o |-> write_strobe_n_o && dq_oe_n_o[7:0] == 8'hFF) // [RULE5]
    else $error("bus contention on read");
  a_byte_float_hi: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (!byte_sel_o && !chip_select_n_o) |-> dq_oe_n_o[14:8] == 7'h7F) // [RULE3]
    else $error("upper lines driven in byte mode");
  a_reset_done_wait: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    $rose(reset_unprotect_n_o) |-> !done_o [*4]) // [RULE13]
    else $error("reset recovery too short");
  a_sel_idle_high: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (state == PFBI_IDLE) |=> chip_select_n_o) // [RULE8]
    else $error("select low while idle");

  c_write:   cover property (@(posedge sys_clk_i) disable iff (!rstn_i) $rose(write_strobe_n_o) && output_gate_n_o);
  c_read:    cover property (@(posedge sys_clk_i) disable iff (!rstn_i) $rose(output_gate_n_o));
  c_reset:   cover property (@(posedge sys_clk_i) disable iff (!rstn_i) $rose(reset_unprotect_n_o));
  c_protect: cover property (@(posedge sys_clk_i) disable iff (!rstn_i) $rose(write_strobe_n_o) && output_gate_hv_o);

endmodule : pfbi_host

// file: pfbi_host_test.sv
// self-checking bench for the flash bus host controller
`timescale 1ns/1ps
module pfbi_host_test;
  import pfbi_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        req_i = 1'b0;
  logic        byte_mode_i = 1'b0;
  pfbi_op_t    op_i = PFBI_OP_READ;
  logic [16:0] addr_i = 17'h0_0000;
  logic [15:0] wdata_i = 16'h0000;
  logic [15:0] fl = 16'h5555;
  logic        busy_o, done_o, dev_ready_o, chip_select_n_o, chip_select_hv_o, output_gate_n_o;
  logic        output_gate_hv_o, write_strobe_n_o, reset_unprotect_n_o, reset_unprotect_hv_o;
  logic        byte_sel_o, addr_bit9_hv_o, rb_low;
  logic [15:0] rdata_o, addr_o, dq_o, dq_oe_n_o, dev_d, dev_en;
  wire  [15:0] dq_i = (~dq_oe_n_o & dq_o) | (dq_oe_n_o & dev_en & dev_d) | (dq_oe_n_o & ~dev_en & fl);
  wire         ready_busy_n_i = ~rb_low;
  int          bad_count = 0;
  int          n_tests = 0;
  realtime     t_low = 0;
  realtime     t_rise = 0;
  localparam logic [7:0] MFR = 8'h3C; // arbitrary value
  localparam logic [7:0] DEV = 8'hC3; // arbitrary value

  pfbi_host #(.PROT_CYC(20)) u_pfbi_host (.sys_clk_i, .rstn_i, .req_i, .op_i, .byte_mode_i, .addr_i,
    .wdata_i, .busy_o, .done_o, .rdata_o, .dev_ready_o, .chip_select_n_o, .chip_select_hv_o,
    .output_gate_n_o, .output_gate_hv_o, .write_strobe_n_o, .reset_unprotect_n_o,
    .reset_unprotect_hv_o, .byte_sel_o, .addr_o, .addr_bit9_hv_o, .dq_i, .dq_o, .dq_oe_n_o,
    .ready_busy_n_i);
  pfbi_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_pfbi_flash_model (.cs_n_i(chip_select_n_o),
    .cs_hv_i(chip_select_hv_o), .og_n_i(output_gate_n_o), .og_hv_i(output_gate_hv_o),
    .we_n_i(write_strobe_n_o), .rp_n_i(reset_unprotect_n_o), .rp_hv_i(reset_unprotect_hv_o),
    .byte_sel_i(byte_sel_o), .addr_i(addr_o), .a9_hv_i(addr_bit9_hv_o), .dq_i(dq_i), .dq_o(dev_d),
    .dq_en_o(dev_en), .rb_low_o(rb_low));

  always #5 sys_clk_i = ~sys_clk_i;
  // released lines wander so a stale value never reads back as good
  always @(posedge sys_clk_i) fl <= ~fl;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  task automatic run_op(input pfbi_op_t op, input logic [16:0] a, input logic [15:0] d, input logic bm);
    int n;
    @(posedge sys_clk_i);
    op_i <= op;
    addr_i <= a;
    wdata_i <= d;
    byte_mode_i <= bm;
    req_i <= 1'b1;
    @(posedge sys_clk_i);
    req_i <= 1'b0;
    #1;
    check({15'h0000, busy_o}, 16'h0001);
    n = 0;
    do begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end while (done_o !== 1'b1 && n < 3000);
    if (n >= 3000) check(16'hDEAD, 16'h0000);
  endtask : run_op

  // =====================================================================
  // reset pin monitor
  always @(negedge reset_unprotect_n_o) t_low = $realtime;
  always @(posedge reset_unprotect_n_o) begin
    t_rise = $realtime;
    if (rstn_i) check({15'h0000, t_rise - t_low >= 500.0}, 16'h0001);
  end

  // =====================================================================
  // scenarios
  task automatic t_word();
    run_op(PFBI_OP_WRITE, {16'h0003, 1'b0}, 16'hC3A5, 1'b0);
    repeat (4) @(posedge sys_clk_i);
    #1;
    check({15'h0000, dev_ready_o}, 16'h0000);
    run_op(PFBI_OP_READ, {16'h0003, 1'b0}, 16'h0000, 1'b0);
    check(rdata_o, 16'hC3A5);
  endtask : t_word

  task automatic t_byte();
    run_op(PFBI_OP_WRITE, {16'h0004, 1'b1}, 16'h005A, 1'b1);
    run_op(PFBI_OP_READ, {16'h0004, 1'b1}, 16'h0000, 1'b1);
    check(rdata_o, 16'h005A);
    run_op(PFBI_OP_READ, {16'h0004, 1'b0}, 16'h0000, 1'b1);
    check(rdata_o, 16'h0000);
    run_op(PFBI_OP_READ, {16'h0004, 1'b0}, 16'h0000, 1'b0);
    check(rdata_o, 16'h5A00);
  endtask : t_byte

  task automatic t_sig();
    run_op(PFBI_OP_SIG, {16'h0000, 1'b0}, 16'h0000, 1'b0);
    check(rdata_o, {8'h00, MFR});
    run_op(PFBI_OP_SIG, {16'h0001, 1'b0}, 16'h0000, 1'b0);
    check(rdata_o, {8'h00, DEV});
  endtask : t_sig

  task automatic t_prot();
    run_op(PFBI_OP_PROTECT, {16'h2005, 1'b0}, 16'h0000, 1'b0);
    run_op(PFBI_OP_PVERIFY, {16'h2002, 1'b0}, 16'h0000, 1'b0);
    check(rdata_o, 16'h0001);
    run_op(PFBI_OP_WRITE, {16'h2005, 1'b0}, 16'h1111, 1'b0);
    run_op(PFBI_OP_READ, {16'h2005, 1'b0}, 16'h0000, 1'b0);
    check(rdata_o, 16'h0000);
    run_op(PFBI_OP_TMP_ON, {16'h2005, 1'b0}, 16'h0000, 1'b0);
    run_op(PFBI_OP_WRITE, {16'h2005, 1'b0}, 16'h1111, 1'b0);
    run_op(PFBI_OP_TMP_OFF, {16'h2005, 1'b0}, 16'h0000, 1'b0);
    run_op(PFBI_OP_READ, {16'h2005, 1'b0}, 16'h0000, 1'b0);
    check(rdata_o, 16'h1111);
    run_op(PFBI_OP_UNPROT, {16'h2000, 1'b0}, 16'h0000, 1'b0);
    run_op(PFBI_OP_PVERIFY, {16'h2002, 1'b0}, 16'h0000, 1'b0);
    check(rdata_o, 16'h0000);
  endtask : t_prot

  task automatic t_reset();
    run_op(PFBI_OP_WRITE, {16'h0006, 1'b0}, 16'h7E81, 1'b0);
    run_op(PFBI_OP_RESET, {16'h0006, 1'b0}, 16'h0000, 1'b0);
    check({15'h0000, $realtime - t_rise >= 10000.0}, 16'h0001);
    check({15'h0000, dev_ready_o}, 16'h0001);
    run_op(PFBI_OP_READ, {16'h0006, 1'b0}, 16'h0000, 1'b0);
    check(rdata_o, 16'h817E);
  endtask : t_reset

  initial begin
    repeat (3) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    t_word();
    t_byte();
    t_sig();
    t_prot();
    t_reset();
    complete_run();
  end

  // whole run is some 2k cycles; limit at 20k keeps a hang short
  initial begin
    #(200_000);
    bad_count++;
    complete_run();
  end
endmodule : pfbi_host_test

// file: pfbi_pkg.sv
// types for the parallel flash bus host controller
package pfbi_pkg;
  typedef enum logic [3:0] {
    PFBI_OP_READ     = 4'h0,
    PFBI_OP_WRITE    = 4'h1,
    PFBI_OP_RESET    = 4'h2,
    PFBI_OP_SIG      = 4'h3,
    PFBI_OP_PVERIFY  = 4'h4,
    PFBI_OP_PROTECT  = 4'h5,
    PFBI_OP_UNPROT   = 4'h6,
    PFBI_OP_TMP_ON   = 4'h7,
    PFBI_OP_TMP_OFF  = 4'h8
  } pfbi_op_t;

  typedef enum logic [2:0] {
    PFBI_IDLE   = 3'b000,
    PFBI_SETUP  = 3'b001,
    PFBI_STROBE = 3'b010,
    PFBI_HOLD   = 3'b011,
    PFBI_LONG   = 3'b100,
    PFBI_WAIT   = 3'b101,
    PFBI_DONE   = 3'b110
  } pfbi_state_t;
endpackage : pfbi_pkg
